/* sw_fault_regs.svh */
// register offsets, field positions, reset values and timing counts of the switch status block
`ifndef SW_FAULT_REGS_SVH
`define SW_FAULT_REGS_SVH

// command address codes (bits 31:25 of a frame)
`define ADDR_SW_STATUS    7'h1F
`define ADDR_FAULT_STATUS 7'h21
`define ADDR_FRAME_CHECK  7'h00
`define ADDR_WET_CFG      7'h02
`define ADDR_MAX          7'h24

// frame layout
`define FRAME_BITS        6'd32
`define BIT_FAULT_SUM     23
`define BIT_INT_FLAG      22
`define SW_MSB            21

// fault flag positions
`define FLG_SPI_ERR       10
`define FLG_HASH          9
`define FLG_UV            7
`define FLG_OV            6
`define FLG_TWARN         5
`define FLG_OT            4
`define FLG_INT_WAKE      3
`define FLG_PIN_WAKE      2
`define FLG_SPI_WAKE      1
`define FLG_POR           0
`define FLG_MASK          24'h0006FF

// reset values
`define FLAGS_RST         24'h000001
`define INT_FLAG_RST      1'b1

// timing
`define CLK_HZ            25000000
`define INT_RELEASE_NS    1000000

`endif

/* sw_fault_pkg.sv */
// types shared by the switch status and fault reporting block
package sw_fault_pkg;

    // everything sampled from outside the clock domain
    typedef struct packed {
        logic        sclk;
        logic        cs_n;
        logic        mosi;
        logic [21:0] sw;
        logic        uv;
        logic        ov;
        logic        twarn;
        logic        ot;
        logic        hash;
        logic        wet;
        logic        int_wake;
        logic        pin_wake;
        logic        spi_wake;
        logic        por;
        logic        lpm_exit;
        logic [5:0]  amux;
    } pins_t;

    // whole state of the block
    typedef struct packed {
        pins_t       s1;
        pins_t       s2;
        pins_t       s3;
        logic [31:0] rx;
        logic [31:0] tx;
        logic [5:0]  bitcnt;
        logic        pend_ok;
        logic [7:0]  pend;
        logic [23:0] flags;
        logic        int_flag;
        logic        lpm_wake;
        logic        int_n;
        logic [15:0] timer;
        logic        miso;
        logic        miso_oe;
    } state_t;

endpackage

/* switch_fault_report.sv */
// switch status and fault flag reporting over a 32-bit serial link
//
// Function
// - status command returns switches next frame
// - closed switch reads one, open zero
// - status frame layout with echo code
// - fault summary ORs all fault bits
// - switch change or new fault sets flag
// - reset sets fault summary and interrupt
// - frame returning interrupt flag clears it
// - persisting condition raises no new interrupt
// - fault read clears flags and summary
// - present condition sets flag again immediately
// - top bits in all frames but two
// - select falls, then 32 clocks shift
// - interrupt pin released 1 ms after select
// - fault read answers in next frame
// - malformed frame sets error bit 10
// - hash mismatch sets bit 9
// - supply under and over voltage latch
// - temperature warning and over-temperature latch
// - wake sources recorded, clear on read
// - battery power-on flag bit 0
// - fault register interrupt copy clears
// - first frame after wake flags high
// - analog selected input reads zero
`include "sw_fault_regs.svh"

// timing overview
// - every pin passes two flops; the third stage only serves edge detection
// - a frame starts two to three clocks after the select pin falls
// - the response is latched whole at frame start, so inputs that move
//   during the frame show up only in the next one
// - the command byte is decoded when select rises, and it chooses
//   what the following frame returns
// - link clock half period must be three clocks or more, because
//   edges are found by sampling, not by clocking on the link clock
// limitation: a frame cut short still ends cleanly at select rise,
//   but is counted as malformed and sets the serial error flag

module switch_fault_report
    import sw_fault_pkg::*;
#(
    parameter int INT_RELEASE_CYC = `INT_RELEASE_NS / (1000000000 / `CLK_HZ)
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // serial link
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        mosi_i,
    output logic             miso_o,
    output logic             miso_oe_o,
    output logic             int_n_o,
    // switch inputs
    input  wire logic [13:0] ground_switch_inputs_i,
    input  wire logic [7:0]  programmable_switch_inputs_i,
    // fault conditions
    input  wire logic        undervoltage_flag_i,
    input  wire logic        overvoltage_flag_i,
    input  wire logic        temp_warning_i,
    input  wire logic        overtemp_flag_i,
    input  wire logic        hash_mismatch_i,
    input  wire logic        wetting_fault_i,
    input  wire logic        battery_supply_por_i,
    // wake sources and low power
    input  wire logic        int_pin_wake_i,
    input  wire logic        wake_pin_wake_i,
    input  wire logic        spi_wake_i,
    input  wire logic        low_power_state_exit_i,
    // analog multiplexer channel
    input  wire logic [5:0]  amux_select_i
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // level fault conditions of one sample, placed at their flag bits
    function automatic logic [23:0] level_conds(input pins_t p);
        logic [23:0] c;
        c = 24'h000000;
        c[`FLG_HASH]  = p.hash;
        c[`FLG_UV]    = p.uv;
        c[`FLG_OV]    = p.ov;
        c[`FLG_TWARN] = p.twarn;
        c[`FLG_OT]    = p.ot;
        c[`FLG_POR]   = p.por;
        return c;
    endfunction

    // switch bits with the analog channel forced open
    function automatic logic [21:0] mask_amux(input logic [21:0] sw, input logic [5:0] sel);
        logic [21:0] m;
        m = sw;
        if (sel != 6'h00 && sel <= 6'h16) begin
            m[5'(sel - 6'h01)] = 1'b0;
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state
    //
    // r holds every flop of the block; n is its next value.
    // keeping one struct makes the reset and register step trivial,
    // at the cost of a wide always_comb that must assign with care.
    // the helper signals below are plain combinational wires.

    state_t      r;
    state_t      n;
    pins_t       pins;
    logic        cs_fall;
    logic        cs_rise;
    logic        sck_rise;
    logic        sck_fall;
    logic        bad_frame;
    logic        fault_sum;
    logic        inf;
    logic        int_clr;
    logic        flt_evt;
    logic        sw_evt;
    logic [23:0] cond;
    logic [23:0] clr;
    logic [21:0] sw_now;
    logic [31:0] resp;

    // raw pins, all from outside the clock domain
    always_comb begin
        pins.sclk     = sclk_i;
        pins.cs_n     = cs_n_i;
        pins.mosi     = mosi_i;
        pins.sw       = {programmable_switch_inputs_i, ground_switch_inputs_i};
        pins.uv       = undervoltage_flag_i;
        pins.ov       = overvoltage_flag_i;
        pins.twarn    = temp_warning_i;
        pins.ot       = overtemp_flag_i;
        pins.hash     = hash_mismatch_i;
        pins.wet      = wetting_fault_i;
        pins.int_wake = int_pin_wake_i;
        pins.pin_wake = wake_pin_wake_i;
        pins.spi_wake = spi_wake_i;
        pins.por      = battery_supply_por_i;
        pins.lpm_exit = low_power_state_exit_i;
        pins.amux     = amux_select_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        n = r;
        // s1 feeds only s2; s3 keeps the last synced value for edge detection
        n.s1 = pins;
        n.s2 = r.s1;
        n.s3 = r.s2;

        cs_fall  = r.s3.cs_n & ~r.s2.cs_n;
        cs_rise  = ~r.s3.cs_n & r.s2.cs_n;
        sck_rise = ~r.s3.sclk & r.s2.sclk & ~r.s2.cs_n;
        sck_fall = r.s3.sclk & ~r.s2.sclk & ~r.s2.cs_n;

        // wrong clock count or an address outside the map
        bad_frame = (r.bitcnt != `FRAME_BITS) || (r.rx[31:25] > `ADDR_MAX);

        // flags set from conditions; a level still present keeps its flag set
        cond = level_conds(r.s2);
        cond[`FLG_SPI_ERR]  = cs_rise & bad_frame;
        cond[`FLG_INT_WAKE] = r.s2.int_wake & ~r.s3.int_wake;
        cond[`FLG_PIN_WAKE] = r.s2.pin_wake & ~r.s3.pin_wake;
        cond[`FLG_SPI_WAKE] = r.s2.spi_wake & ~r.s3.spi_wake;

        // interrupts come from onsets only, so a lasting fault cannot re-fire
        flt_evt = |(level_conds(r.s2) & ~level_conds(r.s3))
                | cond[`FLG_SPI_ERR] | cond[`FLG_INT_WAKE]
                | cond[`FLG_PIN_WAKE] | cond[`FLG_SPI_WAKE]
                | (r.s2.wet & ~r.s3.wet);
        sw_evt  = |(r.s2.sw ^ r.s3.sw);

        fault_sum = (|(r.flags & `FLG_MASK)) | r.s2.wet | r.lpm_wake;
        inf       = r.int_flag | r.lpm_wake;
        sw_now    = mask_amux(r.s2.sw, r.s2.amux);

        // response chosen by the previous command if that frame was good, else the default answer
        clr     = 24'h000000;
        int_clr = 1'b0;
        resp    = 32'h00000000;
        if (r.pend_ok) begin
            resp[31:24] = r.pend;
            case (r.pend[7:1])
                `ADDR_SW_STATUS: begin
                    resp[`SW_MSB:0] = sw_now;
                    resp[`BIT_FAULT_SUM] = fault_sum;
                    resp[`BIT_INT_FLAG]  = inf;
                    int_clr = 1'b1;
                end
                `ADDR_FAULT_STATUS: begin
                    resp[`SW_MSB:0] = r.flags[`SW_MSB:0] & 22'(`FLG_MASK);
                    resp[`BIT_FAULT_SUM] = fault_sum;
                    resp[`BIT_INT_FLAG]  = inf;
                    int_clr = 1'b1;
                    clr = `FLG_MASK;
                end
                // these two own the top bits for configuration
                `ADDR_FRAME_CHECK, `ADDR_WET_CFG: begin
                    resp[`BIT_FAULT_SUM] = 1'b0;
                end
                default: begin
                    resp[`BIT_FAULT_SUM] = fault_sum;
                    resp[`BIT_INT_FLAG]  = inf;
                    int_clr = 1'b1;
                end
            endcase
        end else begin
            resp[`BIT_FAULT_SUM] = fault_sum;
            resp[`BIT_INT_FLAG]  = inf;
            int_clr = 1'b1;
        end

        // frame handling: capture at select fall, shift msb first
        if (cs_fall) begin
            n.tx      = resp;
            n.miso    = resp[31];
            n.miso_oe = 1'b1;
            n.bitcnt  = 6'h00;
            n.lpm_wake = 1'b0;
        end else begin
            clr     = 24'h000000;
            int_clr = 1'b0;
        end
        if (sck_rise) begin
            n.rx = {r.rx[30:0], r.s2.mosi};
            if (r.bitcnt != 6'h3F) begin
                n.bitcnt = r.bitcnt + 6'h01;
            end
        end
        if (sck_fall) begin
            n.tx   = {r.tx[30:0], 1'b0};
            n.miso = r.tx[30];
        end
        if (cs_rise) begin
            n.miso_oe = 1'b0;
            n.pend_ok = ~bad_frame;
            n.pend    = r.rx[31:24];
        end

        // set wins over the read clear
        n.flags    = (r.flags & ~clr) | cond;
        n.int_flag = (r.int_flag & ~int_clr) | sw_evt | flt_evt;
        if (r.s2.lpm_exit & ~r.s3.lpm_exit) begin
            n.lpm_wake = 1'b1;
        end

        // pin low on an event, released a fixed time after select falls
        // the timer reloads on every frame start while the pin is low,
        // so the host always gets the full release delay after its read;
        // a new event in the same cycle as the release keeps the pin low
        if (r.timer != 16'h0000) begin
            n.timer = r.timer - 16'h0001;
            if (r.timer == 16'h0001) begin
                n.int_n = 1'b1;
            end
        end
        if (cs_fall && !r.int_n) begin
            n.timer = 16'(INT_RELEASE_CYC);
        end
        if (sw_evt || flt_evt) begin
            n.int_n = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    //
    // reset parks select high in the sync stages so that no false frame
    // start is seen on release; the power-on flag and interrupt flag
    // come up set, and the interrupt pin comes up asserted

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r          <= '0;
            r.s1.cs_n  <= 1'b1;
            r.s2.cs_n  <= 1'b1;
            r.s3.cs_n  <= 1'b1;
            r.flags    <= `FLAGS_RST;
            r.int_flag <= `INT_FLAG_RST;
            r.int_n    <= 1'b0;
        end else begin
            r <= n;
        end
    end

    // outputs straight from flops
    assign miso_o    = r.miso;
    assign miso_oe_o = r.miso_oe;
    assign int_n_o   = r.int_n;

endmodule // switch_fault_report

/* switch_fault_report_props.sv */
// port assertions for the switch status block
module switch_fault_report_props #(
    parameter int INT_RELEASE_CYC = 25000
) (
    // clock, reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // watched ports
    input wire logic        sclk_i,
    input wire logic        cs_n_i,
    input wire logic        miso_o,
    input wire logic        miso_oe_o,
    input wire logic        int_n_o,
    input wire logic [13:0] ground_switch_inputs_i,
    input wire logic [7:0]  programmable_switch_inputs_i,
    input wire logic        undervoltage_flag_i,
    input wire logic        overtemp_flag_i
);
    localparam int LO = INT_RELEASE_CYC;
    localparam int HI = INT_RELEASE_CYC + 6;
    logic [16:0] since_reg;
    logic        low_at_fall_reg;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////
    // cycles since select fell; saturates so idle never wraps
    always_ff @(posedge clk_i) begin
        if (rst_i || $fell(cs_n_i)) begin
            since_reg <= '0;
        end else if (!(&since_reg)) begin
            since_reg <= since_reg + 17'h1;
        end
    end
    // pin level as the frame began; a long release window needs a counter, not a delay range
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_at_fall_reg <= 1'b0;
        end else if ($fell(cs_n_i)) begin
            low_at_fall_reg <= !int_n_o;
        end
    end
    ////////////////
    a_oe_on_select: assert property ($fell(cs_n_i) |-> ##[2:4] miso_oe_o)
        else $error("miso enable late");
    a_oe_off_idle: assert property (cs_n_i [*6] |-> !miso_oe_o)
        else $error("miso driven while idle");
    a_miso_steady: assert property (miso_oe_o && $past(miso_oe_o) && $changed(miso_o) |-> !sclk_i && !$past(sclk_i, 2))
        else $error("miso moved off clock fall");
    a_int_on_switch: assert property ($changed({programmable_switch_inputs_i, ground_switch_inputs_i}) |-> ##[1:6] !int_n_o)
        else $error("no interrupt on switch change");
    a_int_on_fault: assert property ($rose(overtemp_flag_i) || $rose(undervoltage_flag_i) |-> ##[1:6] !int_n_o)
        else $error("no interrupt on fault");
    a_int_after_reset: assert property ($fell(rst_i) |-> !int_n_o)
        else $error("no power-on interrupt");
    a_int_release_win: assert property (low_at_fall_reg && since_reg == 17'(HI) |-> int_n_o)
        else $error("interrupt not released");
    a_int_no_early: assert property ($rose(int_n_o) |-> int'(since_reg) >= LO)
        else $error("interrupt released early");
endmodule  // switch_fault_report_props

bind switch_fault_report switch_fault_report_props #(.INT_RELEASE_CYC(INT_RELEASE_CYC))
    i_switch_fault_report_props (.*);

/* spi_host_model.sv */
// serial link master standing in for the host controller
module spi_host_model (
    // pacing clock
    input  wire logic clk_i,
    // link pins
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    timeunit 1ns;
    timeprecision 1ns;
    // link clock stands still low outside frames
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // one frame, msb first, half period of four clocks
    task automatic xfer(input logic [31:0] cmd, output logic [31:0] rsp);
        @(negedge clk_i);
        cs_n_o = 1'b0;
        repeat (5) @(negedge clk_i);
        for (int b = 31; b >= 0; b--) begin
            mosi_o = cmd[b];
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b1;
            rsp[b] = miso_i;
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b0;
        end
        repeat (4) @(negedge clk_i);
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;  // no stale data once released
        repeat (6) @(negedge clk_i);
    endtask
endmodule  // spi_host_model

/* tb_top.sv */
// self-checking bench of the switch status block
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] ST = 32'h3E00_0000;
    localparam logic [31:0] FR = 32'h4200_0000;
    localparam int POS [9] = '{0, 1, 2, 3, 4, 5, 6, 7, 9};
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        low_power_state = 1'b0;
    logic        sclk, cs_n, mosi, miso;
    logic [21:0] sw = '0;
    logic [8:0]  flt = '0;
    logic [5:0]  amux = '0;
    logic [31:0] seed = 32'hD657;
    int          fail_count = 0;
    int          checks_done = 0;
    ////////////////
    // design and host
    switch_fault_report #(.INT_RELEASE_CYC(20)) i_switch_fault_report (
        .clk_i, .rst_i, .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
        .miso_oe_o(), .int_n_o(), .ground_switch_inputs_i(sw[13:0]),
        .programmable_switch_inputs_i(sw[21:14]), .undervoltage_flag_i(flt[7]),
        .overvoltage_flag_i(flt[6]), .temp_warning_i(flt[5]), .overtemp_flag_i(flt[4]),
        .hash_mismatch_i(flt[8]), .wetting_fault_i(1'b0), .battery_supply_por_i(flt[0]),
        .int_pin_wake_i(flt[3]), .wake_pin_wake_i(flt[2]), .spi_wake_i(flt[1]),
        .low_power_state_exit_i(low_power_state), .amux_select_i(amux));
    spi_host_model i_spi_host_model (.clk_i, .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
    ////////////////
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // status answer; the analog-selected input reads zero
    function logic [31:0] stw(input logic f, input logic i);
        logic [21:0] d;
        d = sw;
        if (amux != 6'h00) d[amux - 6'h01] = 1'b0;
        return {8'h3E, f, i, d};
    endfunction
    task automatic go(input logic [31:0] cmd, exp, msk = '1);
        logic [31:0] r;
        i_spi_host_model.xfer(cmd, r);
        checks_done++;
        if ((r & msk) !== (exp & msk)) begin
            fail_count++;
            $display("unexpected response: expected %h seen %h", exp, r);
        end
    endtask
    // fault read, then any frame carries the flags
    task automatic rd(input logic [31:0] bits, msk = '1);
        go(FR, stw(1'b1, 1'b0), msk);
        go(ST, FR | 32'h0080_0000 | bits);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    // limit well above the fifty-three frames used
    initial begin
        #3000000;
        fail_count++;
        end_of_test();
    end
    initial begin
        logic [31:0] r;
        r = rnd();
        sw = r[21:0];
        repeat (12) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        repeat (5) @(negedge clk_i);
        i_spi_host_model.xfer(ST, r);
        go(ST, stw(1'b1, 1'b0), 32'hFFBF_FFFF);
        go(ST, stw(1'b1, 1'b0));
        $display("test power_on done");
        repeat (6) begin
            r = rnd();
            sw = sw ^ (r[21:0] | 22'h1);
            amux = 6'(r[28:24] % 5'd23);
            repeat (10) @(negedge clk_i);
            go(ST, stw(1'b1, 1'b1));
        end
        amux = 6'h00;
        rd(32'h0000_0001);
        go(ST, stw(1'b0, 1'b0));
        $display("test switches done");
        // every fault and wake source in turn, except the wetting fault, which stays tied low
        for (int i = 0; i < 9; i++) begin
            flt[i] = 1'b1;
            repeat (3) @(negedge clk_i);
            flt[i] = 1'b0;
            repeat (10) @(negedge clk_i);
            go(FR, stw(1'b1, 1'b1));
            go(ST, FR | 32'h0080_0000 | (32'h1 << POS[i]));
            go(ST, stw(1'b0, 1'b0));
        end
        // over-temperature still present at the read
        flt[4] = 1'b1;
        repeat (10) @(negedge clk_i);
        go(FR, stw(1'b1, 1'b1));
        go(ST, FR | 32'h0080_0010);
        go(ST, stw(1'b1, 1'b0));
        flt[4] = 1'b0;
        rd(32'h0000_0010);
        go(ST, stw(1'b0, 1'b0));
        // bad address, then frame check hides the top bits
        go(32'h6000_0000, stw(1'b0, 1'b0));
        go(32'h0, 32'h0080_0000, 32'hFFBF_FFFF);
        go(ST, 32'h0);
        rd(32'h0000_0400, 32'hFFBF_FFFF);
        go(ST, stw(1'b0, 1'b0));
        low_power_state = 1'b1;
        repeat (3) @(negedge clk_i);
        low_power_state = 1'b0;
        repeat (10) @(negedge clk_i);
        go(ST, stw(1'b1, 1'b1));
        go(ST, stw(1'b0, 1'b0));
        $display("test faults done");
        end_of_test();
    end
endmodule  // tb_top
